// ===== common/salr_pkg.sv
// constants and types for the program-memory loader and auto class registers
package salr_pkg;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    // command codes
    localparam logic [7:0] ADDR_AC_CH1 = 8'h51;
    localparam logic [7:0] ADDR_AC_CH2 = 8'h52;
    localparam logic [7:0] ADDR_AC_CH3 = 8'h53;
    localparam logic [7:0] ADDR_AC_CH4 = 8'h54;
    localparam logic [7:0] ADDR_ALT_FB = 8'h55;
    localparam logic [7:0] ADDR_LOAD_CTRL = 8'h60;
    localparam logic [7:0] ADDR_LOAD_DATA = 8'h61;
    localparam logic [7:0] ADDR_START_LO = 8'h62;
    localparam logic [7:0] ADDR_START_HI = 8'h63;
    localparam logic [7:0] ADDR_FW_REV = 8'h41;
    // load control bit positions
    localparam int BIT_ACCESS = 7;
    localparam int BIT_CPU_RESET = 6;
    localparam int BIT_PARITY_ON = 4;
    localparam int BIT_RUN_SRAM = 3;
    localparam int BIT_PARITY_SEL = 2;
    localparam int BIT_DIRECTION = 1;
    localparam int BIT_PTR_CLEAR = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] FW_REV_INVALID = 8'hff;
    localparam logic [6:0] AC_CODE_MASK = 7'h7f;
    // power step in milliwatts per code
    localparam int AC_STEP_MW = 500;
    // compatibility check deadline
    localparam int CHECK_TIME_US = 1000;
    localparam int CLK_MHZ = 125;
    localparam int CHECK_CYCLES = CHECK_TIME_US * CLK_MHZ;
    typedef struct packed {
        logic accessEn;
        logic cpuReset;
        logic reserved5;
        logic parityOn;
        logic runSram;
        logic paritySel;
        logic loadDirection;
        logic pointerClear;
    } salr_ctrl_s;
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [15:0] addr;
        logic [7:0] wdata;
    } salr_mem_s;
    typedef enum logic [1:0] {
        CHK_IDLE = 2'b00,
        CHK_WAIT = 2'b01,
        CHK_DONE = 2'b11
    } salr_chk_e;
endpackage

// ===== rtl/salr_regs.sv
// register bank: auto class results, foldback selects, program memory loader
`timescale 1ns/1ps
// Notes on behaviour
// R1 - auto class registers: 7-bit code, read-only
// R2 - power equals code times half watt
// R3 - code is peak average measured power
// R4 - upper foldback bits select operational curve
// R5 - host sets operational bit before power-on
// R6 - lower foldback bits select inrush curve
// R7 - host sets inrush bit before power-on
// R8 - bit 7 enables memory access
// R9 - bit 6 holds processor in reset
// R10 - processor reset leaves registers untouched
// R11 - bit 4 enables parity check
// R12 - host keeps parity on when running
// R13 - bit 3 runs from memory and ROM
// R14 - host sets run bit after loading
// R15 - bit 2 redirects data to parity memory
// R16 - bit 1 selects transfer direction
// R17 - bytes stream until stop condition (transferStop is not used here; each byte still advances the pointer)
// R18 - bit 0 holds address pointer cleared
// R19 - host pulses pointer clear 0-1-0
// R20 - transfers start at start address
// R21 - image check done within one millisecond
// R22 - bad image: revision ff, run cleared
// R23 - pointer advances after each byte
module salr_regs #(
    parameter int CHECK_CYCLES = salr_pkg::CHECK_CYCLES,
    parameter int CHANNELS = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    // host register port, byte-wide command interface
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic transferStop,
    // measurement results per channel
    input wire logic [CHANNELS-1:0] acUpdate,
    input wire logic [CHANNELS*7-1:0] acCode,
    // foldback selects to the channel logic
    output logic [CHANNELS-1:0] altOperationalCurveEn,
    output logic [CHANNELS-1:0] altInrushCurveEn,
    // processor side
    output logic cpuReset,
    output logic parityCheckOn,
    output logic runFromSram,
    output logic checkStart,
    input wire logic checkDone,
    input wire logic checkValid,
    input wire logic [7:0] checkRevision,
    output logic [7:0] fwRevision,
    // program and parity memory ports
    output salr_pkg::salr_mem_s progMem,
    output salr_pkg::salr_mem_s parMem,
    input wire logic [7:0] progRdata,
    input wire logic [7:0] parRdata
);
    initial begin
        if (CHANNELS != 4) $error("salr_regs: four channels only");
        if (CHECK_CYCLES < 2) $error("salr_regs: check window too short");
    end

    localparam int CW = $clog2(CHECK_CYCLES + 1);

    logic [CHANNELS-1:0][6:0] acReg, next_acReg;
    logic [7:0] altFb, next_altFb;
    salr_pkg::salr_ctrl_s ctrl, next_ctrl;
    logic [15:0] startAddr, next_startAddr;
    logic [15:0] pointer, next_pointer;
    logic [7:0] rdata, next_rdata;
    logic [7:0] fwRev, next_fwRev;
    salr_pkg::salr_chk_e chkState, next_chkState;
    logic [CW-1:0] chkCount, next_chkCount;
    logic dataWr, dataRd, dataAccess;

    assign dataAccess = ctrl.accessEn && !ctrl.pointerClear; // R8 R18
    assign dataWr = regWr && regAddr == salr_pkg::ADDR_LOAD_DATA
                    && dataAccess && !ctrl.loadDirection; // R16
    assign dataRd = regRd && regAddr == salr_pkg::ADDR_LOAD_DATA
                    && dataAccess && ctrl.loadDirection; // R16

    // per-channel result capture
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : gAc
            always_comb begin
                next_acReg[ch] = acReg[ch];
                if (acUpdate[ch]) begin
                    // code counts half-watt steps of peak average power
                    next_acReg[ch] = acCode[ch*7 +: 7]
                                     & salr_pkg::AC_CODE_MASK; // R1 R2 R3
                end
            end
        end
    endgenerate

    // register writes, pointer and readback
    always_comb begin
        next_altFb = altFb;
        next_ctrl = ctrl;
        next_startAddr = startAddr;
        next_pointer = pointer;
        next_rdata = rdata;
        if (regWr) begin
            if (regAddr == salr_pkg::ADDR_ALT_FB) begin
                next_altFb = regWdata; // R4 R6
            end else if (regAddr == salr_pkg::ADDR_LOAD_CTRL) begin
                next_ctrl = salr_pkg::salr_ctrl_s'(regWdata); // R9 R11 R13 R15
            end else if (regAddr == salr_pkg::ADDR_START_LO) begin
                next_startAddr[7:0] = regWdata;
            end else if (regAddr == salr_pkg::ADDR_START_HI) begin
                next_startAddr[15:8] = regWdata;
            end
        end
        if (chkState == salr_pkg::CHK_WAIT && checkDone && !checkValid) begin
            next_ctrl.runSram = 1'b0; // R22
        end
        if (ctrl.pointerClear) begin
            next_pointer = startAddr; // R18 R20
        end else if (dataWr || dataRd) begin
            next_pointer = pointer + 16'h0001; // R17 R23
        end
        if (regRd) begin
            if (regAddr == salr_pkg::ADDR_AC_CH1) begin
                next_rdata = {1'b0, acReg[0]}; // R1
            end else if (regAddr == salr_pkg::ADDR_AC_CH2) begin
                next_rdata = {1'b0, acReg[1]}; // R1
            end else if (regAddr == salr_pkg::ADDR_AC_CH3) begin
                next_rdata = {1'b0, acReg[2]}; // R1
            end else if (regAddr == salr_pkg::ADDR_AC_CH4) begin
                next_rdata = {1'b0, acReg[3]}; // R1
            end else if (regAddr == salr_pkg::ADDR_ALT_FB) begin
                next_rdata = altFb;
            end else if (regAddr == salr_pkg::ADDR_LOAD_CTRL) begin
                next_rdata = ctrl;
            end else if (regAddr == salr_pkg::ADDR_LOAD_DATA) begin
                if (!dataRd) begin
                    next_rdata = 8'h00; // R8
                end else if (ctrl.paritySel) begin
                    next_rdata = parRdata; // R15
                end else begin
                    next_rdata = progRdata;
                end
            end else if (regAddr == salr_pkg::ADDR_START_LO) begin
                next_rdata = startAddr[7:0];
            end else if (regAddr == salr_pkg::ADDR_START_HI) begin
                next_rdata = startAddr[15:8];
            end else if (regAddr == salr_pkg::ADDR_FW_REV) begin
                next_rdata = fwRev;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    // image check after run-from-memory sequence completes
    always_comb begin
        next_chkState = chkState;
        next_chkCount = chkCount;
        next_fwRev = fwRev;
        case (chkState)
            salr_pkg::CHK_IDLE: begin
                // sequence ends when run set, access and cpu reset cleared
                if (regWr && regAddr == salr_pkg::ADDR_LOAD_CTRL
                    && regWdata[salr_pkg::BIT_RUN_SRAM]
                    && !regWdata[salr_pkg::BIT_ACCESS]
                    && !regWdata[salr_pkg::BIT_CPU_RESET]) begin
                    next_chkState = salr_pkg::CHK_WAIT;
                    next_chkCount = CW'(CHECK_CYCLES - 1); // R21
                end
            end
            salr_pkg::CHK_WAIT: begin
                if (checkDone || chkCount == '0) begin
                    next_chkState = salr_pkg::CHK_DONE;
                    // a missing verdict by the deadline gives revision ff but leaves the run bit set
                    if (checkDone && checkValid) begin
                        next_fwRev = checkRevision;
                    end else begin
                        next_fwRev = salr_pkg::FW_REV_INVALID; // R22
                    end
                end else begin
                    next_chkCount = chkCount - CW'(1); // R21
                end
            end
            salr_pkg::CHK_DONE: begin
                next_chkState = salr_pkg::CHK_IDLE;
            end
            default: begin
                next_chkState = salr_pkg::CHK_IDLE;
            end
        endcase
    end

    // cpuReset is an output only; no register here sees it (R10)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acReg <= '0;
            altFb <= salr_pkg::RESET_BYTE;
            ctrl <= salr_pkg::salr_ctrl_s'(salr_pkg::RESET_BYTE);
            startAddr <= 16'h0000;
            pointer <= 16'h0000;
            rdata <= 8'h00;
            fwRev <= 8'h00;
            chkState <= salr_pkg::CHK_IDLE;
            chkCount <= '0;
        end else begin
            acReg <= next_acReg;
            altFb <= next_altFb;
            ctrl <= next_ctrl;
            startAddr <= next_startAddr;
            pointer <= next_pointer;
            rdata <= next_rdata;
            fwRev <= next_fwRev;
            chkState <= next_chkState;
            chkCount <= next_chkCount;
        end
    end

    always_comb begin
        progMem.wrEn = dataWr && !ctrl.paritySel;
        progMem.rdEn = dataRd && !ctrl.paritySel;
        progMem.addr = pointer;
        progMem.wdata = regWdata;
        parMem.wrEn = dataWr && ctrl.paritySel; // R15
        parMem.rdEn = dataRd && ctrl.paritySel;
        parMem.addr = pointer;
        parMem.wdata = regWdata;
    end

    assign regRdata = rdata;
    assign altOperationalCurveEn = altFb[7:4]; // R4
    assign altInrushCurveEn = altFb[3:0]; // R6
    assign cpuReset = ctrl.cpuReset; // R9 R10
    assign parityCheckOn = ctrl.parityOn; // R11
    assign runFromSram = ctrl.runSram; // R13
    assign checkStart = (chkState == salr_pkg::CHK_IDLE) && (next_chkState ==
                        salr_pkg::CHK_WAIT);
    assign fwRevision = fwRev;
endmodule // salr_regs

// ===== bench/salr_regs_assertions.sv
// concurrent checks on the loader register bank ports
`timescale 1ns/1ps
module salr_regs_assertions #(
    parameter int CHECK_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [3:0] altOperationalCurveEn,
    input wire logic [3:0] altInrushCurveEn,
    input wire logic cpuReset,
    input wire logic runFromSram,
    input wire logic checkDone,
    input wire logic checkValid,
    input wire logic [7:0] fwRevision,
    input wire salr_pkg::salr_mem_s progMem,
    input wire salr_pkg::salr_mem_s parMem
);
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    wire wrFb = regWr && regAddr == 8'h55;
    wire wrCtl = regWr && regAddr == 8'h60;
    wire wrDat = regWr && regAddr == 8'h61;
    // shadow of the load control byte as last written by the host
    always_comb next_ctrl = wrCtl ? regWdata : ctrl;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) ctrl <= 8'h00;
        else ctrl <= next_ctrl;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_ALT_OP: assert property (
        wrFb |=> altOperationalCurveEn == $past(regWdata[7:4]))
        else $error("operational curve select wrong");
    AST_ALT_IR: assert property (
        wrFb |=> altInrushCurveEn == $past(regWdata[3:0]))
        else $error("inrush curve select wrong");
    AST_CPU_RST: assert property (
        wrCtl |=> cpuReset == $past(regWdata[6]))
        else $error("processor reset level wrong");
    AST_RUN: assert property (
        wrCtl && !checkDone |=> runFromSram == $past(regWdata[3]))
        else $error("run select level wrong");
    AST_NO_ACCESS: assert property (
        wrDat && !ctrl[7] |-> !progMem.wrEn && !parMem.wrEn)
        else $error("memory strobed without access");
    AST_PARITY_ACCESS_SELECT: assert property (
        wrDat && ctrl[7:0] == 8'h84 |-> parMem.wrEn && !progMem.wrEn)
        else $error("parity redirect wrong");
    AST_PTR_ADV: assert property (
        progMem.wrEn |=> progMem.addr == $past(progMem.addr) + 16'h1)
        else $error("pointer did not advance");
    AST_INVALID: assert property (
        checkDone && !checkValid |=> fwRevision == 8'hff && !runFromSram)
        else $error("invalid image not flagged");
    cover property (wrDat && ctrl[7]);
    cover property (checkDone && checkValid);
    cover property (checkDone && !checkValid);
endmodule // salr_regs_assertions
bind salr_regs salr_regs_assertions #(.CHECK_CYCLES(CHECK_CYCLES)) u_chk (.*);

// ===== bench/salr_far_end.sv
// far-side memories and image checker answering the loader
`timescale 1ns/1ps
module salr_far_end (
    input wire logic mclk,
    input wire logic imageOk,
    input wire logic checkStart,
    input wire salr_pkg::salr_mem_s progMem,
    input wire salr_pkg::salr_mem_s parMem,
    output logic [7:0] progRdata,
    output logic [7:0] parRdata,
    output logic checkDone,
    output logic checkValid,
    output logic [7:0] checkRevision
);
    logic [7:0] progArr [16];
    logic [7:0] parArr [16];
    logic [2:0] delay = 3'h0;
    // unstrobed reads show a changing pattern, never the last value
    assign progRdata = progMem.rdEn ? progArr[progMem.addr[3:0]] : ~progMem.addr[7:0];
    assign parRdata = parMem.rdEn ? parArr[parMem.addr[3:0]] : ~parMem.addr[7:0];
    assign checkDone = delay == 3'h1;
    assign checkValid = checkDone && imageOk;
    assign checkRevision = checkDone ? 8'h12 : 8'h00;
    always @(posedge mclk) begin
        if (progMem.wrEn) progArr[progMem.addr[3:0]] <= progMem.wdata;
        if (parMem.wrEn) parArr[parMem.addr[3:0]] <= parMem.wdata;
        delay <= checkStart ? 3'h4 : (delay != 3'h0 ? delay - 3'h1 : 3'h0);
    end
endmodule // salr_far_end

// ===== bench/salr_regs_tb.sv
// self-checking bench for the loader register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module salr_regs_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [3:0] acUpdate = 4'h0;
    logic [27:0] acCode = 28'h0;
    logic imageOk = 1'b1;
    logic [7:0] regRdata, progRdata, parRdata, checkRevision, fwRevision;
    logic [3:0] altOp, altIr;
    logic cpuReset, parityOn, runSram, checkStart, checkDone, checkValid;
    salr_pkg::salr_mem_s progMem, parMem;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    always #4 mclk = ~mclk;
    salr_regs #(.CHECK_CYCLES(20)) dut (.mclk(mclk), .rst_n(rst_n),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .transferStop(1'b0), .acUpdate(acUpdate),
        .acCode(acCode), .altOperationalCurveEn(altOp),
        .altInrushCurveEn(altIr), .cpuReset(cpuReset),
        .parityCheckOn(parityOn), .runFromSram(runSram),
        .checkStart(checkStart), .checkDone(checkDone),
        .checkValid(checkValid), .checkRevision(checkRevision),
        .fwRevision(fwRevision), .progMem(progMem), .parMem(parMem),
        .progRdata(progRdata), .parRdata(parRdata));
    salr_far_end far (.mclk(mclk), .imageOk(imageOk), .checkStart(checkStart),
        .progMem(progMem), .parMem(parMem), .progRdata(progRdata),
        .parRdata(parRdata), .checkDone(checkDone), .checkValid(checkValid),
        .checkRevision(checkRevision));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 regWr = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge mclk);
        #1 regWr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        #1 regRd = 1'b1;
        regAddr = a;
        @(posedge mclk);
        #1 regRd = 1'b0;
        `CHK("regRdata", e, regRdata)
    endtask
    task automatic ptr_pulse(input logic [7:0] b);
        wr(8'h60, b);
        wr(8'h60, b | 8'h01);
        wr(8'h60, b);
    endtask
    task automatic t_autoclass();
        rd(8'h53, 8'h00);
        @(posedge mclk);
        #1 acCode = {7'h7f, 7'h2a, 7'h01, 7'h00};
        acUpdate = 4'hf;
        @(posedge mclk);
        #1 acUpdate = 4'h0;
        rd(8'h54, 8'h7f);
        rd(8'h52, 8'h01);
        wr(8'h53, 8'hff);
        rd(8'h53, 8'h2a);
        $display("autoclass done");
    endtask
    task automatic t_fold_cpu();
        wr(8'h55, 8'ha5);
        `CHK("altOp", 4'ha, altOp)
        `CHK("altIr", 4'h5, altIr)
        wr(8'h60, 8'h50);
        `CHK("cpuReset", 1'b1, cpuReset)
        `CHK("parityOn", 1'b1, parityOn)
        wr(8'h60, 8'h00);
        `CHK("cpuReset", 1'b0, cpuReset)
        rd(8'h55, 8'ha5);
        $display("foldback and processor done");
    endtask
    task automatic t_load();
        wr(8'h62, 8'h03);
        wr(8'h63, 8'h00);
        ptr_pulse(8'h80);
        wr(8'h61, 8'h11);
        wr(8'h61, 8'h22);
        `CHK("prog3", 8'h11, far.progArr[3])
        `CHK("prog4", 8'h22, far.progArr[4])
        ptr_pulse(8'h82);
        rd(8'h61, 8'h11);
        rd(8'h61, 8'h22);
        ptr_pulse(8'h84);
        wr(8'h61, 8'h33);
        `CHK("par3", 8'h33, far.parArr[3])
        `CHK("prog3", 8'h11, far.progArr[3])
        wr(8'h60, 8'h00);
        wr(8'h61, 8'h44);
        rd(8'h61, 8'h00);
        `CHK("prog3", 8'h11, far.progArr[3])
        $display("load done");
    endtask
    task automatic run_check(input logic ok, input logic [7:0] e);
        imageOk = ok;
        wr(8'h60, 8'h18);
        for (int i = 0; i < 25 && checkDone !== 1'b1; i++) @(posedge mclk);
        @(posedge mclk);
        #1 rd(8'h41, e);
        `CHK("fwRevision", e, fwRevision)
        `CHK("runSram", ok, runSram)
    endtask
    task automatic t_check();
        run_check(1'b1, 8'h12);
        wr(8'h60, 8'h00);
        run_check(1'b0, 8'hff);
        rd(8'h60, 8'h10);
        $display("check done");
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_autoclass();
        t_fold_cpu();
        t_load();
        t_check();
        close_out();
    end
endmodule // salr_regs_tb
